// *** pcm_bridge_model.sv ***
// Purpose: Bridge model for register access.
// Assumes: Signals move on falling edges.
// Notes: Released data is inverted.
`timescale 1ns/1ps
`default_nettype none
module pcm_bridge_model
(
    // Clock
    input wire logic clk_sys,
    // Register bus
    output logic p_sel,
    output logic p_stb,
    output logic p_write,
    output logic [pcm_pkg::ADDR_W-1:0] p_addr,
    output logic [pcm_pkg::DATA_W-1:0] p_data_in,
    input wire logic [pcm_pkg::DATA_W-1:0] p_data_out
);
    import pcm_pkg::*;
    // Idle bus until the first request
    initial
    begin
        {p_sel, p_stb, p_write, p_addr, p_data_in} = '0;
    end
    // One access: set up, strobe over one edge, then release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(negedge clk_sys);
        {p_sel, p_write, p_addr, p_data_in} = {1'b1, wr, a, d};
        @(negedge clk_sys);
        p_stb = 1'b1;
        @(negedge clk_sys);
        q = p_data_out;
        {p_sel, p_stb, p_data_in} = {2'h0, ~d};
    endtask
endmodule
`default_nettype wire

// *** pcm_clock_gate.sv ***
// Purpose: Glitch-free gate for one clock lane, divided or undivided source.
// Assumes: All inputs are clk_sys flops.
// Notes: Enables move only while clk_sys is low.
`timescale 1ns/1ps
`default_nettype none

module pcm_clock_gate
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Source and enables
    input wire logic src_div,
    input wire logic div_en,
    input wire logic byp_en,
    // Gated clock
    output logic clk_out
);
    import pcm_pkg::*;

    typedef struct packed {
        logic div_en;
        logic byp_en;
    } pcm_gate_st_t;

    pcm_gate_st_t st_r;
    pcm_gate_st_t st_nxt;

    // Divided enable moves only while its source is low
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.div_en = src_div ? st_r.div_en : div_en;
        st_nxt.byp_en = byp_en;
        if (reset)
        begin
            st_nxt = '0;
        end
    end

    // Falling edge: enables move while clk_sys is low
    always_ff @(negedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    assign clk_out = (src_div & st_r.div_en) | (clk_sys & st_r.byp_en);

endmodule
`default_nettype wire

// *** pcm_pkg.sv ***
// Purpose: Constants, register map and types for the power and clock manager.
// Assumes: 8-bit byte offsets, 16-bit data.
// Notes: All design constants.
//
// Functional notes
// - Fast-bus mode: core clocked from bus clock
// - Power-down stops clocks not kept by sleep masks
// - Interrupt in power-down: wake state, then run
// - Command 0x00 clears status, 0x03 enters power-down
// - Power-on reset leaves device in run state
// - Offset 0x00 reads mode history status
// - Status bits 5:4 hold last reset cause
// - Status bits 3:2 hold start condition from last reset
// - Status bits 1:0 hold current running condition
// - Map select resets to 0, software sets 1
// - Bus divider codes 0-6 divide, 7 bypasses
// - Control bit 3 selects fast-bus, resets 1
// - Run bus mask gates listed blocks, resets ones
// - Sleep bus mask adds core, arbiter, decoder
// - Peripheral masks gate ten peripheral clocks
// - Watchdog and timer use gated bus clock
// - Peripheral source: external or divided system clock
// - Reset control bit 0 starts self-clearing reset
// - Kept peripheral reset idle during manual reset

package pcm_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int IRQ_W = 8;
    localparam int CNT_W = 7;
    localparam int BUS_LANES = 16;
    localparam int PER_LANES = 10;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_BUS_RUN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BUS_SLEEP = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_BOOT_MAP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PER_SRC = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PER_SLEEP = 8'h16;
    localparam logic [ADDR_W-1:0] OFS_PER_RUN = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SW_RESET = 8'h30;

    // ------------------------------------------------------------------
    // Reset values and field codes
    // ------------------------------------------------------------------
    localparam logic [3:0] BUS_CTRL_RST = 4'h8;
    localparam int BUS_FAST_BIT = 3;
    localparam logic [15:0] BUS_RUN_RST = 16'hffff;
    localparam logic [15:0] BUS_SLEEP_RST = 16'h0000;
    localparam logic [9:0] PER_RUN_RST = 10'h3ff;
    localparam logic [9:0] PER_SLEEP_RST = 10'h000;
    localparam logic [2:0] PER_SRC_RST = 3'h0;
    localparam logic [2:0] DIV_BYPASS = 3'h7;
    localparam logic [2:0] PER_EXT = 3'h0;
    localparam logic [7:0] CMD_CLEAR = 8'h00;
    localparam logic [7:0] CMD_SLEEP = 8'h03;
    localparam logic [CNT_W-1:0] CNT_WRAP = 7'h7f;

    // Lanes that exist in each mask
    localparam logic [15:0] BUS_RUN_LIVE = 16'h1f81;
    localparam logic [15:0] BUS_RUN_FORCED = 16'he000;
    localparam logic [15:0] BUS_SLEEP_LIVE = 16'hff81;
    localparam int CORE_LANE = 15;
    localparam int PER_WDOG_LANE = 9;
    localparam int PER_TIMER_LANE = 0;

    // Status codes
    localparam logic [1:0] CAUSE_POR = 2'h0;
    localparam logic [1:0] CAUSE_SW = 2'h1;
    localparam logic [1:0] CAUSE_WD_MAN = 2'h2;
    localparam logic [1:0] CAUSE_WD_OVF = 2'h3;
    localparam logic [1:0] COND_POR = 2'h0;
    localparam logic [1:0] COND_WD_OVF = 2'h1;
    localparam logic [1:0] COND_MAN = 2'h2;
    localparam logic [1:0] COND_WAKE = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RST_HOLD_NS = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] RST_HOLD_CNT = 8'(RST_HOLD_CYC);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PCM_RUN, PCM_SLEEP, PCM_WAKE} pcm_mode_t;
    typedef enum logic [1:0] {PCM_RK_NONE, PCM_RK_POR, PCM_RK_WDOG, PCM_RK_MAN} pcm_rst_kind_t;

endpackage

// *** pcm_power_clock_manager.sv ***
// Purpose: Power and clock manager: clock division, gating, modes, resets.
// Assumes: Bridge runs on clk_sys.
// Notes: Divider changes apply at the wrap.
`timescale 1ns/1ps
`default_nettype none

module pcm_power_clock_manager
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Peripheral register bus
    input wire logic p_sel,
    input wire logic p_stb,
    input wire logic p_write,
    input wire logic [pcm_pkg::ADDR_W-1:0] p_addr,
    input wire logic [pcm_pkg::DATA_W-1:0] p_data_in,
    output logic [pcm_pkg::DATA_W-1:0] p_data_out,
    output logic p_data_oe_n,
    // Asynchronous event pins
    input wire logic [pcm_pkg::IRQ_W-1:0] irq_in,
    input wire logic watchdog_overflow_in,
    input wire logic watchdog_manual_in,
    input wire logic pclk_ext,
    // Clock outputs
    output logic [pcm_pkg::BUS_LANES-1:0] bus_clk_gated,
    output logic [pcm_pkg::PER_LANES-1:0] periph_clk_gated,
    output logic core_fast_clock,
    output logic fastbus_mode,
    output logic power_down_n,
    output logic boot_map_select,
    // Reset outputs
    output logic watchdog_overflow_out,
    output logic bus_reset_n,
    output logic periph_reset_n,
    output logic peripheral_reset_keep_n,
    output logic reset_out_n
);
    import pcm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [2:0] bus_sel;
        logic fast;
        logic [2:0] per_sel;
        logic bus_phase;
        logic per_phase;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [IRQ_W-1:0] irq_s1;
        logic [IRQ_W-1:0] irq_s2;
        logic [1:0] wdo_sync;
        logic [1:0] man_sync;
        logic wdo_prev;
        logic man_prev;
        logic [3:0] bus_ctrl;
        logic [15:0] bus_run;
        logic [15:0] bus_sleep;
        logic boot_map;
        logic [2:0] per_src;
        logic [9:0] per_run;
        logic [9:0] per_sleep;
        logic sw_reset;
        logic [5:0] status;
        pcm_mode_t mode;
        pcm_rst_kind_t rst_kind;
        logic [7:0] rst_cnt;
        logic stb_prev;
        logic [DATA_W-1:0] rdata;
        logic oe_n;
    } pcm_state_t;

    pcm_state_t st_r;
    pcm_state_t st_nxt;

    logic wr_go;
    logic [CNT_W-1:0] cnt_inc;
    logic [2:0] per_idx;
    logic irq_any;
    logic wdo_rise;
    logic man_rise;
    logic [DATA_W-1:0] rd_val;
    logic sleeping;
    logic bus_byp;
    logic [15:0] bus_en;
    logic [9:0] per_en;
    logic [15:0] bus_lane_byp;

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    // Write taken on first strobe cycle
    assign wr_go = p_sel & p_stb & p_write & ~st_r.stb_prev;
    assign cnt_inc = st_r.cnt + 7'h01;
    assign per_idx = st_nxt.per_sel - 3'h1;
    // Any request wakes; synchronised on ungated clock
    assign irq_any = |st_r.irq_s2;
    assign wdo_rise = st_r.wdo_sync[1] & ~st_r.wdo_prev;
    assign man_rise = st_r.man_sync[1] & ~st_r.man_prev;

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_val = '0;
        unique case (p_addr)
            OFS_MODE: rd_val[5:0] = st_r.status;
            OFS_BUS_CTRL: rd_val[3:0] = st_r.bus_ctrl;
            OFS_BUS_RUN: rd_val = st_r.bus_run;
            OFS_BUS_SLEEP: rd_val = st_r.bus_sleep;
            OFS_BOOT_MAP: rd_val[0] = st_r.boot_map;
            OFS_PER_SRC: rd_val[2:0] = st_r.per_src;
            OFS_PER_SLEEP: rd_val[9:0] = st_r.per_sleep;
            OFS_PER_RUN: rd_val[9:0] = st_r.per_run;
            OFS_SW_RESET: rd_val[0] = st_r.sw_reset;
            default: rd_val = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // Settings apply at the wrap so
        // no divided pulse is cut short
        st_nxt.cnt = cnt_inc;
        if (st_r.cnt == CNT_WRAP)
        begin
            st_nxt.bus_sel = st_r.bus_ctrl[2:0];
            st_nxt.fast = st_r.bus_ctrl[BUS_FAST_BIT];
            st_nxt.per_sel = st_r.per_src;
        end
        st_nxt.bus_phase = cnt_inc[st_nxt.bus_sel];
        if (st_nxt.per_sel == PER_EXT)
        begin
            st_nxt.per_phase = st_r.ext_sync[1];
        end
        else
        begin
            st_nxt.per_phase = cnt_inc[per_idx];
        end

        // Pin synchronisers, two flops each
        st_nxt.ext_sync = {st_r.ext_sync[0], pclk_ext};
        st_nxt.ext_prev = st_r.ext_sync[1];
        st_nxt.irq_s1 = irq_in;
        st_nxt.irq_s2 = st_r.irq_s1;
        st_nxt.wdo_sync = {st_r.wdo_sync[0], watchdog_overflow_in};
        st_nxt.man_sync = {st_r.man_sync[0], watchdog_manual_in};
        st_nxt.wdo_prev = st_r.wdo_sync[1];
        st_nxt.man_prev = st_r.man_sync[1];

        // Registered read data and enable
        st_nxt.stb_prev = p_sel & p_stb;
        st_nxt.rdata = rd_val;
        st_nxt.oe_n = ~(p_sel & ~p_write);

        if (wr_go)
        begin
            unique case (p_addr)
                OFS_MODE:
                begin
                    if (p_data_in[7:0] == CMD_CLEAR)
                    begin
                        st_nxt.status = '0;
                    end
                    else if (p_data_in[7:0] == CMD_SLEEP && st_r.mode == PCM_RUN)
                    begin
                        st_nxt.mode = PCM_SLEEP;
                    end
                end
                OFS_BUS_CTRL: st_nxt.bus_ctrl = p_data_in[3:0];
                OFS_BUS_RUN: st_nxt.bus_run = p_data_in;
                OFS_BUS_SLEEP: st_nxt.bus_sleep = p_data_in;
                OFS_BOOT_MAP: st_nxt.boot_map = p_data_in[0];
                OFS_PER_SRC: st_nxt.per_src = p_data_in[2:0];
                OFS_PER_SLEEP: st_nxt.per_sleep = p_data_in[9:0];
                OFS_PER_RUN: st_nxt.per_run = p_data_in[9:0];
                // Refused while a procedure runs, so the end-of-procedure clear never races it
                OFS_SW_RESET: st_nxt.sw_reset = st_r.sw_reset
                    | (p_data_in[0] & (st_r.rst_kind == PCM_RK_NONE));
                default: st_nxt.rdata = rd_val;
            endcase
        end

        // Power state machine
        unique case (st_r.mode)
            PCM_RUN: st_nxt.mode = st_nxt.mode;
            PCM_SLEEP:
            begin
                if (irq_any)
                begin
                    st_nxt.mode = PCM_WAKE;
                end
            end
            PCM_WAKE:
            begin
                st_nxt.mode = PCM_RUN;
                st_nxt.status[1:0] = COND_WAKE;
            end
        endcase

        // Reset countdown; software bit clears at its end
        if (st_r.rst_kind != PCM_RK_NONE)
        begin
            st_nxt.mode = PCM_RUN;
            if (st_r.rst_cnt == 8'h00)
            begin
                st_nxt.rst_kind = PCM_RK_NONE;
                if (st_r.rst_kind == PCM_RK_MAN)
                begin
                    st_nxt.sw_reset = 1'b0;
                end
            end
            else
            begin
                st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;
            end
        end

        // Reset events win over a status clear
        if (wdo_rise)
        begin
            st_nxt.rst_kind = PCM_RK_WDOG;
            st_nxt.rst_cnt = RST_HOLD_CNT;
            st_nxt.mode = PCM_RUN;
            st_nxt.status = {CAUSE_WD_OVF, COND_WD_OVF, COND_WD_OVF};
        end
        else if (man_rise)
        begin
            st_nxt.rst_kind = PCM_RK_MAN;
            st_nxt.rst_cnt = RST_HOLD_CNT;
            st_nxt.mode = PCM_RUN;
            st_nxt.boot_map = 1'b0;
            st_nxt.status = {CAUSE_WD_MAN, COND_MAN, COND_MAN};
        end
        else if (wr_go && p_addr == OFS_SW_RESET && p_data_in[0]
            && st_r.rst_kind == PCM_RK_NONE)
        begin
            st_nxt.rst_kind = PCM_RK_MAN;
            st_nxt.rst_cnt = RST_HOLD_CNT;
            st_nxt.mode = PCM_RUN;
            st_nxt.boot_map = 1'b0;
            st_nxt.status = {CAUSE_SW, COND_MAN, COND_MAN};
        end

        // Power-on reset values
        if (reset)
        begin
            st_nxt = '0;
            st_nxt.mode = PCM_RUN;
            st_nxt.status = {CAUSE_POR, COND_POR, COND_POR};
            st_nxt.bus_ctrl = BUS_CTRL_RST;
            st_nxt.bus_run = BUS_RUN_RST;
            st_nxt.bus_sleep = BUS_SLEEP_RST;
            st_nxt.per_run = PER_RUN_RST;
            st_nxt.per_sleep = PER_SLEEP_RST;
            st_nxt.per_src = PER_SRC_RST;
            st_nxt.bus_sel = BUS_CTRL_RST[2:0];
            st_nxt.fast = BUS_CTRL_RST[BUS_FAST_BIT];
            st_nxt.per_sel = PER_SRC_RST;
            st_nxt.boot_map = 1'b0;
            st_nxt.rst_kind = PCM_RK_POR;
            st_nxt.rst_cnt = RST_HOLD_CNT;
            st_nxt.oe_n = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Lane enables
    // ------------------------------------------------------------------
    // Wake keeps the sleep masks
    assign sleeping = (st_r.mode != PCM_RUN);
    assign bus_byp = (st_r.bus_sel == DIV_BYPASS);

    always_comb
    begin
        if (sleeping)
        begin
            bus_en = st_r.bus_sleep & BUS_SLEEP_LIVE;
            per_en = st_r.per_sleep;
        end
        else
        begin
            bus_en = (st_r.bus_run & BUS_RUN_LIVE) | BUS_RUN_FORCED;
            per_en = st_r.per_run;
        end
        // Standard mode: core on system clock
        bus_lane_byp = {BUS_LANES{bus_byp}};
        bus_lane_byp[CORE_LANE] = bus_byp | ~st_r.fast;
    end

    // ------------------------------------------------------------------
    // Clock gates
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BUS_LANES; gi = gi + 1)
        begin : g_bus
            pcm_clock_gate u_gate
            (
                .clk_sys(clk_sys),
                .reset(reset),
                .src_div(st_r.bus_phase),
                .div_en(bus_en[gi] & ~bus_lane_byp[gi]),
                .byp_en(bus_en[gi] & bus_lane_byp[gi]),
                .clk_out(bus_clk_gated[gi])
            );
        end
        for (gi = 0; gi < PER_LANES; gi = gi + 1)
        begin : g_per
            // Watchdog and timer lanes follow the bus clock
            localparam bit ON_BUS = (gi == PER_WDOG_LANE) || (gi == PER_TIMER_LANE);
            pcm_clock_gate u_gate
            (
                .clk_sys(clk_sys),
                .reset(reset),
                .src_div(ON_BUS ? st_r.bus_phase : st_r.per_phase),
                .div_en(per_en[gi] & ~(ON_BUS & bus_byp)),
                .byp_en(per_en[gi] & ON_BUS & bus_byp),
                .clk_out(periph_clk_gated[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign core_fast_clock = bus_clk_gated[CORE_LANE];
    assign fastbus_mode = st_r.fast;
    assign power_down_n = (st_r.mode != PCM_SLEEP);
    assign boot_map_select = st_r.boot_map;
    assign p_data_out = st_r.rdata;
    assign p_data_oe_n = st_r.oe_n;

    // Manual reset spares kept and external resets
    assign bus_reset_n = (st_r.rst_kind == PCM_RK_NONE);
    assign periph_reset_n = (st_r.rst_kind == PCM_RK_NONE);
    assign peripheral_reset_keep_n = (st_r.rst_kind == PCM_RK_NONE)
        || (st_r.rst_kind == PCM_RK_MAN);
    assign reset_out_n = peripheral_reset_keep_n;
    assign watchdog_overflow_out = (st_r.rst_kind == PCM_RK_WDOG);

endmodule
`default_nettype wire

// *** pcm_power_clock_manager_props.sv ***
// Purpose: Port checks for the manager.
// Assumes: One clock, quiet in reset.
// Notes: The bench counts clock rates.
`timescale 1ns/1ps
`default_nettype none
module pcm_power_clock_manager_props
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register bus
    input wire logic p_sel,
    input wire logic p_stb,
    input wire logic p_write,
    input wire logic [pcm_pkg::ADDR_W-1:0] p_addr,
    input wire logic [pcm_pkg::DATA_W-1:0] p_data_in,
    input wire logic [pcm_pkg::DATA_W-1:0] p_data_out,
    input wire logic p_data_oe_n,
    // Events, clocks and resets
    input wire logic [pcm_pkg::IRQ_W-1:0] irq_in,
    input wire logic [pcm_pkg::BUS_LANES-1:0] bus_clk_gated,
    input wire logic core_fast_clock,
    input wire logic power_down_n,
    input wire logic bus_reset_n,
    input wire logic periph_reset_n,
    input wire logic peripheral_reset_keep_n
);
    import pcm_pkg::*;
    logic stb_r;
    logic rd_r;
    logic take;
    // Strobe and read history
    always_ff @(posedge clk_sys)
    begin
        stb_r <= p_stb;
        rd_r <= p_sel & ~p_write;
    end
    // Command write taken at this edge
    assign take = p_sel & p_stb & p_write & ~stb_r & (p_addr == OFS_MODE);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_sleep_entry: assert property (
        take && p_data_in[7:0] == CMD_SLEEP && power_down_n && bus_reset_n |=> !power_down_n)
        else $error("No sleep");
    a_bad_command: assert property (
        take && p_data_in[7:0] != CMD_CLEAR && p_data_in[7:0] != CMD_SLEEP && power_down_n
        |=> power_down_n) else $error("Bad command acted");
    a_wake_bound: assert property (
        !power_down_n && irq_in != '0 |-> ##[1:4] power_down_n) else $error("No wake-up");
    a_clear_status: assert property (
        take && p_data_in[7:0] == CMD_CLEAR ##1 (p_addr == OFS_MODE) [*2]
        |-> p_data_out[5:0] == 6'h00) else $error("No clear");
    a_oe_follow: assert property (
        p_data_oe_n == !rd_r) else $error("Enable late");
    a_map_narrow: assert property (
        p_addr == OFS_BOOT_MAP |=> p_data_out[15:1] == 15'h0000) else $error("Map wide");
    a_core_lane: assert property (
        core_fast_clock == bus_clk_gated[CORE_LANE]) else $error("Core lane");
    a_reserved_off: assert property (
        bus_clk_gated[6:1] == 6'h00) else $error("Reserved lane");
    a_keep_subset: assert property (
        !peripheral_reset_keep_n |-> !periph_reset_n) else $error("Kept reset");
    a_reset_hold: assert property (
        $fell(bus_reset_n) |=> !bus_reset_n [*8]) else $error("Reset short");
    c_sleep: cover property (take && p_data_in[7:0] == CMD_SLEEP);
    c_wake: cover property ($rose(power_down_n));
    c_manual: cover property ($fell(bus_reset_n) && peripheral_reset_keep_n);
endmodule
`default_nettype wire

// *** power_clock_manager_tb_top.sv ***
// Purpose: Self-checking bench for the power and clock manager.
// Assumes: Inputs move on falling edges.
// Notes: 512-cycle windows fit every divider.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module power_clock_manager_tb_top;
    import pcm_pkg::*;
    // ----------------------------------------------------------------
    // Signals and tables
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic p_sel, p_stb, p_write, p_data_oe_n, core_clk, pd_n, boot_map, bus_rst_n, keep_n;
    logic [ADDR_W-1:0] p_addr;
    logic [DATA_W-1:0] p_data_in, p_data_out, q;
    logic [IRQ_W-1:0] irq_in = 8'h00;
    logic wd_ovf = 1'b0;
    logic wd_man = 1'b0;
    logic pclk_ext = 1'b0;
    logic [BUS_LANES-1:0] bus_clk;
    logic [PER_LANES-1:0] per_clk;
    logic [31:0] lfsr = 32'had84;
    int err_count = 0;
    int n_checks = 0;
    int n_bus, n_core, n_wdg, n_per, n_brg, bus_exp;
    localparam logic [7:0] OFFS [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h16, 8'h18};
    localparam logic [15:0] MSKS [7] = '{16'h000f, 16'hffff, 16'hffff, 16'h0001, 16'h0007,
        16'h03ff, 16'h03ff};
    localparam logic [5:0] STATS [3] = '{6'h1a, 6'h35, 6'h2a};
    pcm_power_clock_manager u_pcm_power_clock_manager (.clk_sys(clk_sys), .reset(reset),
        .p_sel(p_sel), .p_stb(p_stb), .p_write(p_write), .p_addr(p_addr),
        .p_data_in(p_data_in), .p_data_out(p_data_out), .p_data_oe_n(p_data_oe_n),
        .irq_in(irq_in), .watchdog_overflow_in(wd_ovf), .watchdog_manual_in(wd_man),
        .pclk_ext(pclk_ext), .bus_clk_gated(bus_clk), .periph_clk_gated(per_clk),
        .core_fast_clock(core_clk), .fastbus_mode(), .power_down_n(pd_n),
        .boot_map_select(boot_map), .watchdog_overflow_out(), .bus_reset_n(bus_rst_n),
        .periph_reset_n(), .peripheral_reset_keep_n(keep_n), .reset_out_n());
    pcm_bridge_model u_pcm_bridge_model (.clk_sys(clk_sys), .p_sel(p_sel), .p_stb(p_stb),
        .p_write(p_write), .p_addr(p_addr), .p_data_in(p_data_in), .p_data_out(p_data_out));
    // System clock and quarter-rate external clock
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        forever #16 pclk_ext = ~pclk_ext;
    end
    // Edge counters: SRAM, core, watchdog, first serial port, bridge
    always @(posedge bus_clk[7]) n_bus++;
    always @(posedge core_clk) n_core++;
    always @(posedge per_clk[9]) n_wdg++;
    always @(posedge per_clk[1]) n_per++;
    always @(posedge bus_clk[12]) n_brg++;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_pcm_bridge_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        u_pcm_bridge_model.xfer(1'b0, a, 16'h0000, q);
        `CHK(q, e)
    endtask
    // Settle, then count one window
    task automatic measure();
        repeat (4) @(negedge clk_sys);
        {n_bus, n_core, n_wdg, n_per, n_brg} = '0;
        repeat (512) @(negedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for bus reset (which=1) or power-down level
    task automatic wait_lvl(input logic which, input logic lvl);
        for (int i = 0; i < 400 && (which ? bus_rst_n : pd_n) !== lvl; i++)
            @(negedge clk_sys);
        if ((which ? bus_rst_n : pd_n) !== lvl)
        begin
            `CHK(which ? bus_rst_n : pd_n, lvl)
            report_and_stop();
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        rd_chk(OFS_MODE, 16'h0000);
        rd_chk(OFS_BUS_CTRL, 16'h0008);
        rd_chk(OFS_BUS_RUN, 16'hffff);
        rd_chk(OFS_BUS_SLEEP, 16'h0000);
        rd_chk(OFS_BOOT_MAP, 16'h0000);
        rd_chk(OFS_PER_SRC, 16'h0000);
        rd_chk(OFS_PER_SLEEP, 16'h0000);
        rd_chk(OFS_PER_RUN, 16'h03ff);
        rd_chk(8'h20, 16'h0000);
        repeat (2) foreach (OFFS[i])
        begin
            lfsr = lfsr_next(lfsr);
            wr(OFFS[i], lfsr[15:0]);
            rd_chk(OFFS[i], lfsr[15:0] & MSKS[i]);
        end
        $display("Register test done");
        wr(OFS_BUS_RUN, 16'hffff);
        wr(OFS_PER_RUN, 16'h03ff);
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_BUS_CTRL, {12'h000, c[0], c[2:0]});
            wr(OFS_PER_SRC, {13'h0, c[2:0]});
            repeat (140) @(negedge clk_sys);
            measure();
            bus_exp = (c == 7) ? 512 : 512 >> (c + 1);
            `CHK(n_bus, bus_exp)
            `CHK(n_core, c[0] ? bus_exp : 512)
            `CHK(n_wdg, bus_exp)
            `CHK(n_per, (c == 0) ? 128 : 512 >> c)
        end
        wr(OFS_BUS_RUN, 16'hff7f);
        wr(OFS_PER_RUN, 16'h03fd);
        measure();
        `CHK(n_bus + n_per, 0)
        `CHK(n_brg, 512)
        $display("Clock test done");
        wr(OFS_BUS_RUN, 16'hffff);
        wr(OFS_PER_RUN, 16'h03ff);
        wr(OFS_BUS_SLEEP, 16'h0080);
        wr(OFS_PER_SLEEP, 16'h0000);
        wr(OFS_MODE, 16'h0005);
        @(negedge clk_sys);
        `CHK(pd_n, 1'b1)
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_MODE, 16'h0003);
            @(negedge clk_sys);
            `CHK(pd_n, 1'b0)
            measure();
            `CHK(n_bus, 512)
            `CHK(n_brg + n_core + n_per + n_wdg, 0)
            lfsr = lfsr_next(lfsr);
            irq_in = 8'h01 << lfsr[2:0];
            wait_lvl(1'b0, 1'b1);
            irq_in = 8'h00;
            rd_chk(OFS_MODE, 16'h0003);
        end
        wr(OFS_MODE, 16'h0000);
        rd_chk(OFS_MODE, 16'h0000);
        $display("Power-down test done");
        for (int e = 0; e < 3; e++)
        begin
            wr(OFS_BOOT_MAP, 16'h0001);
            `CHK(boot_map, 1'b1)
            if (e == 0)
                wr(OFS_SW_RESET, 16'h0001);
            wd_ovf = (e == 1);
            wd_man = (e == 2);
            wait_lvl(1'b1, 1'b0);
            `CHK(keep_n, e != 1)
            {wd_ovf, wd_man} = 2'h0;
            wait_lvl(1'b1, 1'b1);
            rd_chk(OFS_SW_RESET, 16'h0000);
            rd_chk(OFS_MODE, {10'h000, STATS[e]});
            `CHK(boot_map, e == 1)
        end
        $display("Reset test done");
        report_and_stop();
    end
endmodule
bind pcm_power_clock_manager pcm_power_clock_manager_props u_pcm_power_clock_manager_props (.*);
`default_nettype wire
